// [design/irc_consts.vh]
`ifndef IRC_CONSTS_VH
`define IRC_CONSTS_VH

// Register indices as printed (word indices, not byte addresses: byte address = 4 * index)
`define IRC_IDX_CONV_A_LO      6'h04
`define IRC_IDX_CONV_A_HI      6'h05
`define IRC_IDX_CONV_B_LO      6'h06
// Byte addresses on the register bus (all eight address bits used for decode)
`define IRC_ADDR_CONV_A_LO     8'h10
`define IRC_ADDR_CONV_A_HI     8'h14
`define IRC_ADDR_CONV_B_LO     8'h18
// Field positions inside a register word
`define IRC_DIR_BIT            15
`define IRC_IDX_MSB            14
`define IRC_IDX_LSB            9
`define IRC_RSVD_BIT           8
`define IRC_RANGE_MSB          7
// Reset values
`define IRC_RST_CONV_A_LO      16'h08ff
`define IRC_RST_CONV_A_HI      16'h0aff
`define IRC_RST_CONV_B_LO      16'h0cff
`define IRC_RST_FIELD          2'h3
`define IRC_RST_RANGES         8'hff
// Range codes and decoded front-end selections
`define IRC_CODE_10V_A         2'h0
`define IRC_CODE_2V5           2'h1
`define IRC_CODE_5V            2'h2
`define IRC_CODE_10V_B         2'h3
`define IRC_SEL_10V            3'h1
`define IRC_SEL_5V             3'h2
`define IRC_SEL_2V5            3'h4
// Bus responses
`define IRC_RESP_OKAY          2'h0
`define IRC_RESP_SLVERR        2'h2

`endif

// [design/irc_input_range_regs.v]
`timescale 1ns/10ps
`include "irc_consts.vh"

// Notes on behaviour
// - Bit 15: 0 read, 1 write request
// - Bits 14..9 hold own register index
// - Bit 8 reserved, always reads zero
// - Decode codes: 00/11 10V, 01 2.5V, 10 5V
// - Index 4: conv A inputs 3..0
// - Index 5: conv A inputs 7..4
// - Index 6: conv B inputs 3..0
// - Reset loads 11b in every field
module irc_input_range_regs (
    // Clock and reset
    input  wire        i_mclk,
    input  wire        i_nrst,
    // AXI4-Lite write address
    input  wire [7:0]  i_awaddr,
    input  wire [2:0]  i_awprot,
    input  wire        i_awvalid,
    output reg         o_awready,
    // AXI4-Lite write data
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    input  wire        i_wvalid,
    output reg         o_wready,
    // AXI4-Lite write response
    output reg  [1:0]  o_bresp,
    output reg         o_bvalid,
    input  wire        i_bready,
    // AXI4-Lite read address
    input  wire [7:0]  i_araddr,
    input  wire [2:0]  i_arprot,
    input  wire        i_arvalid,
    output reg         o_arready,
    // AXI4-Lite read data
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    output reg         o_rvalid,
    input  wire        i_rready,
    // Front-end range selections, one-hot per channel (10V, 5V, 2.5V)
    output wire [2:0]  o_conv_a_input0_range,
    output wire [2:0]  o_conv_a_input1_range,
    output wire [2:0]  o_conv_a_input2_range,
    output wire [2:0]  o_conv_a_input3_range,
    output wire [2:0]  o_conv_a_input4_range,
    output wire [2:0]  o_conv_a_input5_range,
    output wire [2:0]  o_conv_a_input6_range,
    output wire [2:0]  o_conv_a_input7_range,
    output wire [2:0]  o_conv_b_input0_range,
    output wire [2:0]  o_conv_b_input1_range,
    output wire [2:0]  o_conv_b_input2_range,
    output wire [2:0]  o_conv_b_input3_range
);

    // ============================================================
    // Stored state
    // ============================================================
    // Only the eight range bits are kept per register; the index field and
    // the reserved bit are rebuilt on every read, so they can never drift
    reg  [7:0]  conv_a_lo_reg;     // Conv A inputs 3..0 range codes
    reg  [7:0]  conv_a_hi_reg;     // Conv A inputs 7..4 range codes
    reg  [7:0]  conv_b_lo_reg;     // Conv B inputs 3..0 range codes
    reg         aw_held_reg;       // Write address captured
    reg         w_held_reg;        // Write data captured
    reg  [7:0]  aw_addr_reg;       // Captured write address
    reg  [15:0] w_data_reg;        // Captured low half of write data
    reg  [1:0]  w_strb_reg;        // Captured low byte enables
    reg  [31:0] rdata_next;        // Read mux
    reg  [1:0]  rresp_next;        // Read response
    reg  [15:0] ctl_word;          // Write word seen as a control word
    reg         wr_hit;            // Write address maps to a register
    wire        do_write;          // Both halves present, response free

    // ============================================================
    // Write path
    // ============================================================

    // A write fires once address and data are both held and no response waits
    assign do_write = aw_held_reg && w_held_reg && !o_bvalid;

    // Address decode for writes; unmapped addresses answer SLVERR
    // The address is compared in full, so no alias reaches a register
    always @* begin
        ctl_word = w_data_reg;
        case (aw_addr_reg)
            `IRC_ADDR_CONV_A_LO,
            `IRC_ADDR_CONV_A_HI,
            `IRC_ADDR_CONV_B_LO: wr_hit = 1'b1;
            default:             wr_hit = 1'b0;
        endcase
    end

    // Channel accepts, capture, register update and response
    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            // Bus idle, slots empty, ranges at the widest setting
            o_awready     <= 1'b0;
            o_wready      <= 1'b0;
            o_bvalid      <= 1'b0;
            o_bresp       <= `IRC_RESP_OKAY;
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 16'h0000;
            w_strb_reg    <= 2'h0;
            conv_a_lo_reg <= `IRC_RST_RANGES;
            conv_a_hi_reg <= `IRC_RST_RANGES;
            conv_b_lo_reg <= `IRC_RST_RANGES;
        end else begin
            // Ready is a one-cycle pulse while the slot is empty
            o_awready <= !aw_held_reg && i_awvalid && !o_awready;
            o_wready  <= !w_held_reg && i_wvalid && !o_wready;
            // Address slot fills on its own handshake
            if (o_awready && i_awvalid) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= i_awaddr;
            end
            // Data slot fills independently, so AW and W may come in any order
            if (o_wready && i_wvalid) begin
                w_held_reg <= 1'b1;
                w_data_reg <= i_wdata[15:0];
                w_strb_reg <= i_wstrb[1:0];
            end
            // Commit: empty both slots and raise the response in one step
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                o_bvalid    <= 1'b1;
                o_bresp     <= wr_hit ? `IRC_RESP_OKAY : `IRC_RESP_SLVERR;
                // Direction bit 0 means a read request: nothing is stored
                // Index field and bit 8 are never stored, so they are ignored
                if (ctl_word[`IRC_DIR_BIT] && w_strb_reg[0]) begin
                    case (aw_addr_reg)
                        `IRC_ADDR_CONV_A_LO: conv_a_lo_reg <= ctl_word[`IRC_RANGE_MSB:0];
                        `IRC_ADDR_CONV_A_HI: conv_a_hi_reg <= ctl_word[`IRC_RANGE_MSB:0];
                        `IRC_ADDR_CONV_B_LO: conv_b_lo_reg <= ctl_word[`IRC_RANGE_MSB:0];
                        default:             conv_a_lo_reg <= conv_a_lo_reg;
                    endcase
                end
            // Response stands until the host takes it
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // ============================================================
    // Read path
    // ============================================================

    // Word = direction 0, own index, reserved 0, range codes
    // The address is decoded in full: aliases read as unmapped
    always @* begin
        rresp_next = `IRC_RESP_OKAY;
        case (i_araddr)
            `IRC_ADDR_CONV_A_LO: rdata_next = {16'h0000, 1'b0, `IRC_IDX_CONV_A_LO, 1'b0, conv_a_lo_reg};
            `IRC_ADDR_CONV_A_HI: rdata_next = {16'h0000, 1'b0, `IRC_IDX_CONV_A_HI, 1'b0, conv_a_hi_reg};
            `IRC_ADDR_CONV_B_LO: rdata_next = {16'h0000, 1'b0, `IRC_IDX_CONV_B_LO, 1'b0, conv_b_lo_reg};
            default: begin
                // Unmapped: zero data and SLVERR
                rdata_next = 32'h00000000;
                rresp_next = `IRC_RESP_SLVERR;
            end
        endcase
    end

    // Take the read address and present data one edge later
    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            // No read in flight after reset
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h00000000;
            o_rresp   <= `IRC_RESP_OKAY;
        end else begin
            // Only one read is accepted while rvalid is low
            o_arready <= i_arvalid && !o_rvalid && !o_arready;
            // Capture data and response at the address handshake
            if (o_arready && i_arvalid) begin
                o_rvalid <= 1'b1;
                o_rdata  <= rdata_next;
                o_rresp  <= rresp_next;
            // Data and response hold steady until rready is seen
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // ============================================================
    // Front-end decode, one decoder per channel
    // ============================================================
    // Each channel has its own decoder flop, so every range output is a
    // register and the front end never sees decode glitches.
    // The cost is one cycle of lag after a register write lands.

    // ============================================================
    // Conv A inputs 0..3, from the index 4 register
    // ============================================================

    // Conv A input 0, bits 1..0
    irc_range_decode u_dec_a0 (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .i_code (conv_a_lo_reg[1:0]),
        .o_sel  (o_conv_a_input0_range)
    );

    // Conv A input 1, bits 3..2
    irc_range_decode u_dec_a1 (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .i_code (conv_a_lo_reg[3:2]),
        .o_sel  (o_conv_a_input1_range)
    );

    // Conv A input 2, bits 5..4
    irc_range_decode u_dec_a2 (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .i_code (conv_a_lo_reg[5:4]),
        .o_sel  (o_conv_a_input2_range)
    );

    // Conv A input 3, bits 7..6
    irc_range_decode u_dec_a3 (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .i_code (conv_a_lo_reg[7:6]),
        .o_sel  (o_conv_a_input3_range)
    );

    // ============================================================
    // Conv A inputs 4..7, from the index 5 register
    // ============================================================

    // Conv A input 4, bits 1..0
    irc_range_decode u_dec_a4 (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .i_code (conv_a_hi_reg[1:0]),
        .o_sel  (o_conv_a_input4_range)
    );

    // Conv A input 5, bits 3..2
    irc_range_decode u_dec_a5 (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .i_code (conv_a_hi_reg[3:2]),
        .o_sel  (o_conv_a_input5_range)
    );

    // Conv A input 6, bits 5..4
    irc_range_decode u_dec_a6 (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .i_code (conv_a_hi_reg[5:4]),
        .o_sel  (o_conv_a_input6_range)
    );

    // Conv A input 7, bits 7..6
    irc_range_decode u_dec_a7 (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .i_code (conv_a_hi_reg[7:6]),
        .o_sel  (o_conv_a_input7_range)
    );

    // ============================================================
    // Conv B inputs 0..3, from the index 6 register
    // ============================================================

    // Conv B input 0, bits 1..0
    irc_range_decode u_dec_b0 (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .i_code (conv_b_lo_reg[1:0]),
        .o_sel  (o_conv_b_input0_range)
    );

    // Conv B input 1, bits 3..2
    irc_range_decode u_dec_b1 (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .i_code (conv_b_lo_reg[3:2]),
        .o_sel  (o_conv_b_input1_range)
    );

    // Conv B input 2, bits 5..4
    irc_range_decode u_dec_b2 (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .i_code (conv_b_lo_reg[5:4]),
        .o_sel  (o_conv_b_input2_range)
    );

    // Conv B input 3, bits 7..6
    irc_range_decode u_dec_b3 (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .i_code (conv_b_lo_reg[7:6]),
        .o_sel  (o_conv_b_input3_range)
    );

endmodule // irc_input_range_regs

// [design/irc_range_decode.v]
`timescale 1ns/10ps
`include "irc_consts.vh"

// ============================================================
// Range code decoder, one per channel, registered output
// ============================================================
module irc_range_decode (
    // Clock and reset
    input  wire       i_mclk,
    input  wire       i_nrst,
    // Stored range code
    input  wire [1:0] i_code,
    // One-hot front-end selection: bit0 10V, bit1 5V, bit2 2.5V
    output reg  [2:0] o_sel
);

    reg [2:0] sel_next;  // Combinational decode

    // Two codes map to the widest range
    always @* begin
        case (i_code)
            `IRC_CODE_2V5: sel_next = `IRC_SEL_2V5;
            `IRC_CODE_5V:  sel_next = `IRC_SEL_5V;
            default:       sel_next = `IRC_SEL_10V;
        endcase
    end

    // Registered so the front end sees a clean level
    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_sel <= `IRC_SEL_10V;
        end else begin
            o_sel <= sel_next;
        end
    end

endmodule // irc_range_decode

// [verification/input_range_config_regs_test.sv]
`timescale 1ns/10ps
`include "irc_consts.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
// ==========
// Bench top
module input_range_config_regs_test;
    logic       i_mclk = 1'b0;
    logic       i_nrst = 1'b0;
    int         n_errors = 0;
    int         check_count = 0;
    wire [7:0]  awaddr, araddr;
    wire [31:0] wdata, rdata;
    wire [1:0]  bresp, rresp;
    wire        awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
    wire [2:0]  rg [0:11]; // Selections, conv A 0..7 then conv B 0..3
    irc_host_model u_host (.i_mclk(i_mclk), .o_awaddr(awaddr), .o_awvalid(awv), .o_wdata(wdata), .o_wvalid(wv),
        .o_bready(br), .o_araddr(araddr), .o_arvalid(arv), .o_rready(rr), .i_awready(awr), .i_wready(wr_),
        .i_bresp(bresp), .i_bvalid(bv), .i_arready(arr), .i_rdata(rdata), .i_rresp(rresp), .i_rvalid(rv));
    irc_input_range_regs dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_awaddr(awaddr), .i_awprot(3'h0),
        .i_awvalid(awv), .o_awready(awr), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(wr_),
        .o_bresp(bresp), .o_bvalid(bv), .i_bready(br), .i_araddr(araddr), .i_arprot(3'h0), .i_arvalid(arv),
        .o_arready(arr), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv), .i_rready(rr),
        .o_conv_a_input0_range(rg[0]), .o_conv_a_input1_range(rg[1]), .o_conv_a_input2_range(rg[2]),
        .o_conv_a_input3_range(rg[3]), .o_conv_a_input4_range(rg[4]), .o_conv_a_input5_range(rg[5]),
        .o_conv_a_input6_range(rg[6]), .o_conv_a_input7_range(rg[7]), .o_conv_b_input0_range(rg[8]),
        .o_conv_b_input1_range(rg[9]), .o_conv_b_input2_range(rg[10]), .o_conv_b_input3_range(rg[11]));
    initial forever #2 i_mclk = ~i_mclk;
    task automatic rchk(input [7:0] a, input [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        u_host.rd(a, d, r);
        `CHK("rdata", e, d)
        `CHK("rresp", `IRC_RESP_OKAY, r)
    endtask
    // Four channels from index b, highest first
    task automatic gchk(input int b, input [11:0] e);
        `CHK("ranges", e, {rg[b+3], rg[b+2], rg[b+1], rg[b]})
    endtask
    task automatic t_reset;
        rchk(`IRC_ADDR_CONV_A_LO, 32'h08ff);
        rchk(`IRC_ADDR_CONV_A_HI, 32'h0aff);
        rchk(`IRC_ADDR_CONV_B_LO, 32'h0cff);
        for (int b = 0; b < 12; b += 4) gchk(b, 12'h249);
        $display("test reset done");
    endtask
    // All four codes in one word, reserved bit written as one
    task automatic t_codes;
        logic [1:0] r;
        u_host.wr(`IRC_ADDR_CONV_A_LO, 1'b1, 8'h2d, r);
        `CHK("bresp", `IRC_RESP_OKAY, r)
        rchk(`IRC_ADDR_CONV_A_LO, 32'h082d);
        gchk(0, {3'h1, 3'h2, 3'h1, 3'h4});
        $display("test codes done");
    endtask
    task automatic t_map;
        logic [1:0] r;
        u_host.wr(`IRC_ADDR_CONV_A_HI, 1'b1, 8'h1b, r);
        u_host.wr(`IRC_ADDR_CONV_B_LO, 1'b1, 8'h6c, r);
        rchk(`IRC_ADDR_CONV_A_HI, 32'h0a1b);
        rchk(`IRC_ADDR_CONV_B_LO, 32'h0c6c);
        gchk(4, {3'h1, 3'h4, 3'h2, 3'h1});
        gchk(8, {3'h4, 3'h2, 3'h1, 3'h1});
        $display("test map done");
    endtask
    // Read-direction write and unmapped place change nothing
    task automatic t_refuse;
        logic [1:0]  r;
        logic [31:0] d;
        u_host.wr(`IRC_ADDR_CONV_A_LO, 1'b0, 8'h00, r);
        rchk(`IRC_ADDR_CONV_A_LO, 32'h082d);
        u_host.wr(8'h1c, 1'b1, 8'h00, r);
        `CHK("bresp", `IRC_RESP_SLVERR, r)
        u_host.rd(8'h1c, d, r);
        `CHK("rdata", 32'h0, d)
        `CHK("rresp", `IRC_RESP_SLVERR, r)
        rchk(`IRC_ADDR_CONV_B_LO, 32'h0c6c);
        $display("test refuse done");
    endtask
    // Reset in mid-run restores every field to the widest range
    task automatic t_rerst;
        @(posedge i_mclk);
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_nrst <= 1'b1;
        rchk(`IRC_ADDR_CONV_A_HI, 32'h0aff);
        for (int b = 0; b < 12; b += 4) gchk(b, 12'h249);
        $display("test rerst done");
    endtask
    task automatic summarize;
        n_errors += u_host.n_hang;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Watchdog at 50000 cycles, far above the run of the tests
    initial begin
        #200000;
        n_errors++;
        summarize;
    end
    initial begin
        repeat (4) @(posedge i_mclk);
        i_nrst <= 1'b1;
        t_reset;
        t_codes;
        t_map;
        t_refuse;
        t_rerst;
        summarize;
    end
endmodule // input_range_config_regs_test

// [verification/irc_checker.sv]
`timescale 1ns/10ps
// ==========
// Bus handshake and range output checks
module irc_checker (
    input wire        i_mclk,
    input wire        i_nrst,
    input wire        o_awready,
    input wire        o_wready,
    input wire        o_bvalid,
    input wire        i_bready,
    input wire        i_arvalid,
    input wire        o_arready,
    input wire        o_rvalid,
    input wire        i_rready,
    input wire [31:0] o_rdata,
    input wire [2:0]  o_conv_a_input0_range
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    aw_pulse_a: assert property (o_awready |=> !o_awready) else $error("awready too long");
    wr_answer_a: assert property (o_awready && o_wready |-> ##2 o_bvalid) else $error("late bvalid");
    b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid) else $error("bvalid dropped");
    rd_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid) else $error("late rvalid");
    r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata)) else $error("rdata moved");
    rsvd_zero_a: assert property (o_rvalid |-> !o_rdata[8] && !o_rdata[15]) else $error("bit 8 or 15 set");
    own_index_a: assert property (o_rvalid |-> o_rdata[14:9] inside {6'h4, 6'h5, 6'h6} || o_rdata == 32'h0)
        else $error("bad index field");
    sel_onehot_a: assert property ($onehot(o_conv_a_input0_range)) else $error("selection not one-hot");
    rst_wide_a: assert property ($rose(i_nrst) |-> o_conv_a_input0_range == 3'h1) else $error("reset range");
    cover property (o_bvalid && i_bready);
    cover property (o_rvalid && i_rready);
    cover property (o_conv_a_input0_range == 3'h4);
endmodule // irc_checker

bind irc_input_range_regs irc_checker u_chk (.i_mclk(i_mclk), .i_nrst(i_nrst), .o_awready(o_awready),
    .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
    .o_conv_a_input0_range(o_conv_a_input0_range));

// [verification/irc_host_model.sv]
`timescale 1ns/10ps
// ==========
// Host controller: AXI4-Lite master, one access at a time
module irc_host_model (
    input  wire        i_mclk,
    output reg  [7:0]  o_awaddr = 8'h0,
    output reg         o_awvalid = 1'b0,
    output reg  [31:0] o_wdata = 32'h0,
    output reg         o_wvalid = 1'b0,
    output reg         o_bready = 1'b0,
    output reg  [7:0]  o_araddr = 8'h0,
    output reg         o_arvalid = 1'b0,
    output reg         o_rready = 1'b0,
    input  wire        i_awready,
    input  wire        i_wready,
    input  wire [1:0]  i_bresp,
    input  wire        i_bvalid,
    input  wire        i_arready,
    input  wire [31:0] i_rdata,
    input  wire [1:0]  i_rresp,
    input  wire        i_rvalid
);
    int n_hang = 0; // Waits that ran out
    // Word: direction, own index, reserved set on purpose, ranges
    task automatic wr(input [7:0] a, input d, input [7:0] r, output [1:0] resp);
        int i;
        resp = 2'h1;
        @(posedge i_mclk);
        o_awaddr <= a;
        o_wdata <= {16'h0, d, a[7:2], 1'b1, r};
        o_awvalid <= 1'b1;
        o_wvalid <= 1'b1;
        o_bready <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge i_mclk);
            if (i_awready) o_awvalid <= 1'b0;
            if (i_wready) o_wvalid <= 1'b0;
            if (i_bvalid) begin
                resp = i_bresp;
                break;
            end
        end
        // Released lines show the inverse, never a stale copy
        o_bready <= 1'b0;
        o_awaddr <= ~a;
        o_wdata <= ~o_wdata;
        if (i == 64) n_hang++;
    endtask
    task automatic rd(input [7:0] a, output [31:0] d, output [1:0] resp);
        int i;
        d = 32'h0;
        resp = 2'h1;
        @(posedge i_mclk);
        o_araddr <= a;
        o_arvalid <= 1'b1;
        o_rready <= 1'b1;
        for (i = 0; i < 64; i++) begin
            @(posedge i_mclk);
            if (i_arready) o_arvalid <= 1'b0;
            if (i_rvalid) begin
                d = i_rdata;
                resp = i_rresp;
                break;
            end
        end
        o_rready <= 1'b0;
        o_araddr <= ~a;
        if (i == 64) n_hang++;
    endtask
endmodule // irc_host_model
